// ==== ack_ctrl_consts.svh ====
// constants for the acknowledge control block
`ifndef ACK_CTRL_CONSTS_SVH
`define ACK_CTRL_CONSTS_SVH
`define ACK_BIT_LAST_DATA 4'h8
`define ACK_BIT_ACK_SLOT 4'h9
`define ACK_BIT_ZERO 4'h0
`define ACK_BIT_STEP 4'h1
`define ACK_EXT_CODE 5'h1e
`define ACK_SHIFT_ZERO 8'h00
`endif

// ==== ack_ctrl_pkg.sv ====
// types shared by the acknowledge control modules
package ack_ctrl_pkg;
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_ADDR,
        PH_DATA
    } phase_t;

    typedef struct packed {
        logic scl_meta;
        logic scl_sync;
        logic scl_prev;
        logic sda_meta;
        logic sda_sync;
        logic sda_prev;
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
    } mon_state_t;

    typedef struct packed {
        phase_t phase;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic flag;
        logic selected;
        logic ext_seen;
        logic match;
        logic ack_drive;
        logic scl_hold;
    } ack_state_t;
endpackage : ack_ctrl_pkg

// ==== line_events_if.sv ====
// events seen on the serial clock and data lines
`timescale 1ns/10ps
interface line_events_if;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_level;
    modport src (
        output scl_rise,
        output scl_fall,
        output start_seen,
        output stop_seen,
        output sda_level
    );
    modport snk (
        input scl_rise,
        input scl_fall,
        input start_seen,
        input stop_seen,
        input sda_level
    );
endinterface : line_events_if

// ==== line_monitor.sv ====
// synchroniser and edge, start and stop detector for the bus lines
`timescale 1ns/10ps
module line_monitor (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_scl,
    input wire logic i_sda,
    line_events_if.src ev
);
    ack_ctrl_pkg::mon_state_t s_q;
    ack_ctrl_pkg::mon_state_t s_d;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        // meta flops feed only the sync flops
        s_d.scl_meta = i_scl;
        s_d.sda_meta = i_sda;
        s_d.scl_sync = s_q.scl_meta;
        s_d.sda_sync = s_q.sda_meta;
        s_d.scl_prev = s_q.scl_sync;
        s_d.sda_prev = s_q.sda_sync;
        s_d.scl_rise = s_q.scl_sync & ~s_q.scl_prev;
        s_d.scl_fall = ~s_q.scl_sync & s_q.scl_prev;
        // data edges while the clock is high mark start and stop
        s_d.start_seen = s_q.scl_sync & s_q.scl_prev
                         & s_q.sda_prev & ~s_q.sda_sync;
        s_d.stop_seen = s_q.scl_sync & s_q.scl_prev
                        & ~s_q.sda_prev & s_q.sda_sync;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_q <= '{scl_meta: 1'b1, scl_sync: 1'b1, scl_prev: 1'b1,
                     sda_meta: 1'b1, sda_sync: 1'b1, sda_prev: 1'b1,
                     default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign ev.scl_rise = s_q.scl_rise;
    assign ev.scl_fall = s_q.scl_fall;
    assign ev.start_seen = s_q.start_seen;
    assign ev.stop_seen = s_q.stop_seen;
    assign ev.sda_level = s_q.sda_sync;
endmodule : line_monitor

// ==== i2c_acknowledge_control.sv ====
// acknowledge and wait control of a receiving bus interface unit
`timescale 1ns/10ps
`include "ack_ctrl_consts.svh"
module i2c_acknowledge_control (
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic i_SCL_IN,
    input wire logic i_SDA_IN,
    input wire logic i_ACK_ENABLE_SET,
    input wire logic i_ACK_ENABLE_CLR,
    input wire logic i_BUS_UNIT_ENABLE,
    input wire logic i_WAIT_POINT_SELECT,
    input wire logic [6:0] i_OWN_SLAVE_ADDRESS,
    input wire logic i_WAIT_RELEASE,
    output logic o_SDA_OUT,
    output logic o_SDA_OE,
    output logic o_SCL_OUT,
    output logic o_SCL_OE,
    output logic o_ACK_ENABLE_FLAG,
    output logic o_ADDR_MATCH,
    output logic o_EXT_CODE,
    output logic o_WAIT_ACTIVE
);
    ack_ctrl_pkg::ack_state_t s_q;
    ack_ctrl_pkg::ack_state_t s_d;

    line_events_if ev ();

    line_monitor mon (
        .i_clk(I_REF_CLK),
        .i_rst(I_RESET),
        .i_scl(i_SCL_IN),
        .i_sda(i_SDA_IN),
        .ev(ev.src)
    );

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic is_ext_code(input logic [7:0] b);
        is_ext_code = (b[7:3] == `ACK_EXT_CODE);
    endfunction : is_ext_code

    function automatic logic is_match(input logic [7:0] b,
                                      input logic [6:0] own);
        is_match = (b[7:1] == own);
    endfunction : is_match

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        // set wins over a clear in the same cycle
        if (i_ACK_ENABLE_SET) begin
            s_d.flag = 1'b1;
        end else if (i_ACK_ENABLE_CLR) begin
            s_d.flag = 1'b0;
        end
        if (i_WAIT_RELEASE) begin
            s_d.scl_hold = 1'b0;
        end
        if (!i_BUS_UNIT_ENABLE) begin
            // disabled unit drives nothing whatever the flag says
            s_d.phase = ack_ctrl_pkg::PH_IDLE;
            s_d.bit_cnt = `ACK_BIT_ZERO;
            s_d.ack_drive = 1'b0;
            s_d.scl_hold = 1'b0;
            s_d.selected = 1'b0;
            s_d.ext_seen = 1'b0;
            s_d.match = 1'b0;
        end else if (ev.stop_seen) begin
            s_d.phase = ack_ctrl_pkg::PH_IDLE;
            s_d.bit_cnt = `ACK_BIT_ZERO;
            s_d.ack_drive = 1'b0;
            s_d.selected = 1'b0;
        end else if (ev.start_seen) begin
            // a restart abandons any byte in progress
            s_d.phase = ack_ctrl_pkg::PH_ADDR;
            s_d.bit_cnt = `ACK_BIT_ZERO;
            s_d.ack_drive = 1'b0;
            s_d.selected = 1'b0;
            s_d.ext_seen = 1'b0;
            s_d.match = 1'b0;
        end else if (s_q.phase != ack_ctrl_pkg::PH_IDLE) begin
            if (ev.scl_rise) begin
                s_d.bit_cnt = s_q.bit_cnt + `ACK_BIT_STEP;
                if (s_q.bit_cnt < `ACK_BIT_LAST_DATA) begin
                    s_d.shift = {s_q.shift[6:0], ev.sda_level};
                end
            end
            if (ev.scl_fall && s_q.bit_cnt == `ACK_BIT_LAST_DATA) begin
                unique case (s_q.phase)
                    ack_ctrl_pkg::PH_ADDR: begin
                        s_d.match = is_match(s_q.shift,
                                             i_OWN_SLAVE_ADDRESS);
                        s_d.ext_seen = is_ext_code(s_q.shift);
                        s_d.selected = s_d.match | s_d.ext_seen;
                        // match acks always, extension code by flag
                        s_d.ack_drive = s_d.match
                            | (s_d.ext_seen & s_q.flag);
                        if (s_d.ext_seen && !s_d.match) begin
                            s_d.scl_hold = 1'b1;
                        end
                    end
                    ack_ctrl_pkg::PH_DATA: begin
                        s_d.ack_drive = s_q.flag;
                        if (!i_WAIT_POINT_SELECT) begin
                            s_d.scl_hold = 1'b1;
                        end
                    end
                    default: begin
                        s_d.ack_drive = 1'b0;
                    end
                endcase
            end
            if (ev.scl_fall && s_q.bit_cnt == `ACK_BIT_ACK_SLOT) begin
                // ack held for the whole ninth period, dropped here
                s_d.ack_drive = 1'b0;
                s_d.bit_cnt = `ACK_BIT_ZERO;
                if (s_q.phase == ack_ctrl_pkg::PH_ADDR && s_q.match) begin
                    s_d.scl_hold = 1'b1;
                end
                if (s_q.phase == ack_ctrl_pkg::PH_DATA
                    && i_WAIT_POINT_SELECT) begin
                    s_d.scl_hold = 1'b1;
                end
                // unaddressed unit stays silent until the next start
                s_d.phase = s_q.selected ? ack_ctrl_pkg::PH_DATA
                                         : ack_ctrl_pkg::PH_IDLE;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge I_REF_CLK) begin
        if (I_RESET) begin
            s_q <= '{phase: ack_ctrl_pkg::PH_IDLE,
                     bit_cnt: `ACK_BIT_ZERO,
                     shift: `ACK_SHIFT_ZERO,
                     default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // lines are open drain: only ever pulled low
    assign o_SDA_OUT = 1'b0;
    assign o_SDA_OE = s_q.ack_drive;
    assign o_SCL_OUT = 1'b0;
    assign o_SCL_OE = s_q.scl_hold;
    assign o_ACK_ENABLE_FLAG = s_q.flag;
    assign o_ADDR_MATCH = s_q.match;
    assign o_EXT_CODE = s_q.ext_seen;
    assign o_WAIT_ACTIVE = s_q.scl_hold;
endmodule : i2c_acknowledge_control

// ==== ack_ctrl_sva.sv ====
// port checks for the acknowledge control block
`timescale 1ns/10ps
module ack_ctrl_sva (
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic i_ACK_ENABLE_SET,
    input wire logic i_ACK_ENABLE_CLR,
    input wire logic i_BUS_UNIT_ENABLE,
    input wire logic i_WAIT_RELEASE,
    input wire logic o_SDA_OE,
    input wire logic o_SCL_OE,
    input wire logic o_ACK_ENABLE_FLAG,
    input wire logic o_ADDR_MATCH,
    input wire logic o_EXT_CODE,
    input wire logic o_WAIT_ACTIVE
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);
    flag_set_a: assert property (
        i_ACK_ENABLE_SET |=> o_ACK_ENABLE_FLAG) else $error("flag not set");
    flag_clr_a: assert property (
        i_ACK_ENABLE_CLR && !i_ACK_ENABLE_SET |=> !o_ACK_ENABLE_FLAG)
        else $error("flag not cleared");
    off_quiet_a: assert property (
        !i_BUS_UNIT_ENABLE |=> !o_SDA_OE && !o_SCL_OE)
        else $error("lines driven while disabled");
    ack_len_a: assert property (
        $rose(o_SDA_OE) |-> o_SDA_OE[*8]) else $error("ack too short");
    match_ack_a: assert property (
        $rose(o_ADDR_MATCH) && i_BUS_UNIT_ENABLE |-> ##[0:1] o_SDA_OE)
        else $error("match not acked");
    ext_noack_a: assert property (
        $rose(o_EXT_CODE) && !o_ADDR_MATCH && !o_ACK_ENABLE_FLAG
        |-> (!o_SDA_OE)[*3]) else $error("extension acked");
    ext_wait_a: assert property (
        $rose(o_EXT_CODE) && !o_ADDR_MATCH |-> ##[0:1] o_SCL_OE)
        else $error("no wait at eighth fall");
    wait_hold_a: assert property (
        o_SCL_OE && !i_WAIT_RELEASE && i_BUS_UNIT_ENABLE
        |=> o_SCL_OE && o_WAIT_ACTIVE) else $error("wait dropped");
endmodule : ack_ctrl_sva
bind i2c_acknowledge_control ack_ctrl_sva chk_u (.I_REF_CLK, .I_RESET,
    .i_ACK_ENABLE_SET, .i_ACK_ENABLE_CLR, .i_BUS_UNIT_ENABLE,
    .i_WAIT_RELEASE, .o_SDA_OE, .o_SCL_OE, .o_ACK_ENABLE_FLAG,
    .o_ADDR_MATCH, .o_EXT_CODE, .o_WAIT_ACTIVE);

// ==== bus_master_model.sv ====
// bus master model on the far side of the serial lines
`timescale 1ns/10ps
module bus_master_model (
    input wire logic i_clk,
    input wire logic i_scl_hold,
    input wire logic i_scl_drv,
    input wire logic i_sda_pull,
    input wire logic i_sda_drv,
    output logic o_scl,
    output logic o_sda
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    int stuck = 0;
    // open drain with pull-ups: whoever pulls low wins
    // an enabled driver puts its level on the wire, so a wrong level shows
    assign o_scl = scl_q & (~i_scl_hold | i_scl_drv);
    assign o_sda = sda_q & (~i_sda_pull | i_sda_drv);
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    // a held clock is waited out, but not forever
    task automatic rise();
        scl_q = 1'b1;
        for (int i = 0; i < 2000 && !o_scl; i++) tick(1);
        if (!o_scl) stuck++;
        tick(8);
    endtask : rise
    task automatic bit_out(input logic b, output logic s);
        tick(2);
        sda_q = b;
        tick(8);
        rise();
        s = o_sda;
        scl_q = 1'b0;
    endtask : bit_out
    task automatic send(input logic [7:0] d, output logic a,
        output logic [1:0] w);
        logic s;
        for (int i = 7; i >= 0; i--) bit_out(d[i], s);
        tick(7);
        w[1] = i_scl_hold;
        bit_out(1'b1, s);
        a = !s;
        tick(7);
        w[0] = i_scl_hold;
    endtask : send
    task automatic start();
        sda_q = 1'b0;
        tick(8);
        scl_q = 1'b0;
    endtask : start
    task automatic stop();
        tick(2);
        sda_q = 1'b0;
        tick(8);
        rise();
        sda_q = 1'b1;
        tick(8);
    endtask : stop
endmodule : bus_master_model

// ==== tb_i2c_acknowledge_control.sv ====
// self-checking bench for the acknowledge control block
`timescale 1ns/10ps
module tb_i2c_acknowledge_control;
    logic I_REF_CLK = 1'b0;
    logic I_RESET = 1'b1;
    logic i_ACK_ENABLE_SET = 1'b0;
    logic i_ACK_ENABLE_CLR = 1'b0;
    logic i_BUS_UNIT_ENABLE = 1'b0;
    logic i_WAIT_POINT_SELECT = 1'b0;
    logic [6:0] i_OWN_SLAVE_ADDRESS = 7'h00;
    logic i_WAIT_RELEASE = 1'b0;
    logic i_SCL_IN, i_SDA_IN, o_SDA_OE, o_SCL_OE, o_ACK_ENABLE_FLAG;
    logic o_ADDR_MATCH, o_EXT_CODE, o_WAIT_ACTIVE, a, f, e, ws;
    logic o_SDA_OUT, o_SCL_OUT;
    logic [1:0] w;
    logic [7:0] ab;
    int n_fail = 0, tests_run = 0, wcnt = 0, kind;
    initial forever #10 I_REF_CLK = ~I_REF_CLK;
    i2c_acknowledge_control dut_u (.I_REF_CLK, .I_RESET, .i_SCL_IN,
        .i_SDA_IN, .i_ACK_ENABLE_SET, .i_ACK_ENABLE_CLR, .i_BUS_UNIT_ENABLE,
        .i_WAIT_POINT_SELECT, .i_OWN_SLAVE_ADDRESS, .i_WAIT_RELEASE,
        .o_SDA_OUT, .o_SDA_OE, .o_SCL_OUT, .o_SCL_OE, .o_ACK_ENABLE_FLAG,
        .o_ADDR_MATCH, .o_EXT_CODE, .o_WAIT_ACTIVE);
    bus_master_model m_u (.i_clk(I_REF_CLK), .i_scl_hold(o_SCL_OE),
        .i_scl_drv(o_SCL_OUT), .i_sda_pull(o_SDA_OE),
        .i_sda_drv(o_SDA_OUT), .o_scl(i_SCL_IN), .o_sda(i_SDA_IN));
    // software lets a held clock go after a pause long enough to see it
    always @(posedge I_REF_CLK) begin
        #1;
        wcnt = o_WAIT_ACTIVE ? wcnt + 1 : 0;
        i_WAIT_RELEASE = (wcnt == 12);
    end
    task automatic check(input string nm, input logic [1:0] x,
        input logic [1:0] g);
        tests_run++;
        if (g !== x) begin
            n_fail++;
            $display("unexpected %s expected %b seen %b", nm, x, g);
        end
    endtask : check
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results
    task automatic pulse(input logic [1:0] sc);
        {i_ACK_ENABLE_SET, i_ACK_ENABLE_CLR} = sc;
        m_u.tick(1);
        {i_ACK_ENABLE_SET, i_ACK_ENABLE_CLR} = 2'b00;
        m_u.tick(1);
    endtask : pulse
    initial begin
        #400000;
        n_fail++;
        results();
    end
    initial begin
        void'($urandom(32'he415));
        repeat (4) @(posedge I_REF_CLK);
        #1 I_RESET = 1'b0;
        i_BUS_UNIT_ENABLE = 1'b1;
        m_u.tick(6);
        check("flag", 0, o_ACK_ENABLE_FLAG);
        check("drive levels", 0, {o_SDA_OUT, o_SCL_OUT});
        pulse(2'b11);
        check("flag", 1, o_ACK_ENABLE_FLAG);
        for (int k = 0; k < 13; k++) begin
            kind = k % 3;
            f = (k / 3) % 2 != 0 || k == 12;
            e = (k != 12);
            ws = 1'((k / 6) % 2);
            pulse({f, !f});
            check("flag", f, o_ACK_ENABLE_FLAG);
            i_BUS_UNIT_ENABLE = e;
            i_WAIT_POINT_SELECT = ws;
            i_OWN_SLAVE_ADDRESS = 7'($urandom_range(119));
            ab = {i_OWN_SLAVE_ADDRESS ^ 7'(kind), 1'($urandom)};
            if (kind == 2) ab[7:3] = 5'h1e;
            m_u.start();
            m_u.send(ab, a, w);
            check("ack", e && (kind == 0 || kind == 2 && f), a);
            check("wait", {e && kind == 2, e && kind == 0}, w);
            if (e) check("match", kind == 0, o_ADDR_MATCH);
            if (e) check("ext", kind == 2, o_EXT_CODE);
            for (int j = 0; j < 2 && e && kind == 0; j++) begin
                m_u.send(8'($urandom), a, w);
                check("data ack", f, a);
                check("data wait", {!ws, ws}, w);
            end
            m_u.stop();
            $display("case %0d done", k);
        end
        // a reset in mid-run must drop the flag left set by the last case
        I_RESET = 1'b1;
        m_u.tick(2);
        I_RESET = 1'b0;
        m_u.tick(1);
        check("flag reset", 0, o_ACK_ENABLE_FLAG);
        check("lines after reset", 0, {o_SDA_OE, o_SCL_OE});
        check("stalls", 0, m_u.stuck != 0);
        results();
    end
endmodule : tb_i2c_acknowledge_control
